/* design/scb_pkg.sv */
// package: register map, strap positions and encodings for the strap capture block
package scb_pkg;
	// ==========================================================
	// register bus
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] ADDR_STRAP_STATUS = 8'h00;
	localparam logic [7:0] ADDR_OVERRIDE = 8'h04;
	localparam logic [7:0] ADDR_EFFECTIVE = 8'h08;
	// ==========================================================
	// strap bit positions in the capture vector
	localparam int STRAP_N = 5;
	localparam int POS_SUPPLY = 0;
	localparam int POS_BOOT = 1;
	localparam int POS_DLQUAL = 2;
	localparam int POS_LOGTIM = 3;
	localparam int POS_TIMSEL = 4;
	// weak pull direction per strap, 1 = pull-up
	localparam logic [4:0] PULL_UP_MASK = 5'h1a;
	localparam logic [4:0] PULL_DOWN_MASK = 5'h05;
	// ==========================================================
	// override register fields
	localparam int OVR_SUPPLY_EN = 0;
	localparam int OVR_SUPPLY_VAL = 1;
	localparam int OVR_TIMING_EN = 2;
	localparam int OVR_SAMPLE_VAL = 3;
	localparam int OVR_DRIVE_VAL = 4;
	localparam int OVR_W = 5;
	localparam logic [4:0] OVR_RESET = 5'h00;
	// effective register fields
	localparam int EFF_SUPPLY = 0;
	localparam int EFF_BOOT0 = 1;
	localparam int EFF_BOOT1 = 2;
	localparam int EFF_LOG = 3;
	localparam int EFF_SAMPLE = 4;
	localparam int EFF_DRIVE = 5;
	localparam int EFF_VALID = 6;
	localparam int EFF_W = 7;
	// ==========================================================
	// encodings
	localparam logic RAIL_3V3 = 1'b0;
	localparam logic RAIL_1V8 = 1'b1;
	localparam logic EDGE_FALL = 1'b0;
	localparam logic EDGE_RISE = 1'b1;
	typedef enum logic [1:0] {
		SCB_BOOT_FLASH = 2'b00,
		SCB_BOOT_DOWNLOAD = 2'b01,
		SCB_BOOT_UNDEF = 2'b10
	} scb_boot_e;
	typedef enum logic [0:0] {
		SCB_ST_CAPTURE = 1'b0,
		SCB_ST_HOLD = 1'b1
	} scb_state_e;
endpackage

/* design/scb_strap_capture.sv */
// strap capture and boot configuration decode
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
// ==========================================================
module scb_strap_capture
	import scb_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// strap pins, shared with their functional roles
	input wire logic supplySelectStrap,
	input wire logic bootSelectStrap,
	input wire logic downloadQualifyStrap,
	input wire logic logAndTimingStrap,
	input wire logic timingSelectStrap,
	// weak pull controls for the pad cells
	output logic [STRAP_N-1:0] strapPullUpEn,
	output logic [STRAP_N-1:0] strapPullDownEn,
	output logic strapPinsReleased,
	// decoded configuration
	output logic railSelect1v8,
	output logic bootFromFlash,
	output logic bootDownload,
	output logic uart0TransmitLogEn,
	output logic sdioSampleRising,
	output logic sdioDriveRising,
	output logic configValid,
	// register port
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [DATA_W-1:0] regRdata
);

	// ==========================================================
	// capture
	scb_state_e state;
	scb_state_e next_state;
	logic [STRAP_N-1:0] strapLatch;
	logic [OVR_W-1:0] overrideBits;
	wire [STRAP_N-1:0] pinVector;
	wire captureNow;

	assign pinVector = {timingSelectStrap, logAndTimingStrap, downloadQualifyStrap,
		bootSelectStrap, supplySelectStrap};
	// first clock after reset release takes all bits together
	assign captureNow = (state == SCB_ST_CAPTURE);
	assign next_state = SCB_ST_HOLD;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state <= SCB_ST_CAPTURE;
		end else begin
			state <= next_state;
		end
	end

	// no reset on the latch: a constant would be all it could take, and the
	// pin level must be caught by a clocked edge after release
	always_ff @(posedge clk_sys) begin
		if (captureNow) begin
			strapLatch <= pinVector;
		end
	end
	// once in hold, nothing writes strapLatch again

	// ==========================================================
	// pulls: on while in reset and the capture cycle, off afterwards
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			strapPullUpEn <= PULL_UP_MASK;
			strapPullDownEn <= PULL_DOWN_MASK;
			strapPinsReleased <= 1'b0;
		end else begin
			strapPullUpEn <= '0;
			strapPullDownEn <= '0;
			strapPinsReleased <= 1'b1;
		end
	end

	// ==========================================================
	// decode
	wire [STRAP_N-1:0] capVec;
	wire strapSupply;
	wire strapBoot;
	wire strapQual;
	wire strapLog;
	wire strapTim;
	wire effSupply;
	wire effSample;
	wire effDrive;
	wire decFlash;
	wire decDownload;

	// strap values are seen in the capture cycle itself
	assign capVec = captureNow ? pinVector : strapLatch;
	assign strapSupply = capVec[POS_SUPPLY];
	assign strapBoot = capVec[POS_BOOT];
	assign strapQual = capVec[POS_DLQUAL];
	assign strapLog = capVec[POS_LOGTIM];
	assign strapTim = capVec[POS_TIMSEL];

	assign effSupply = overrideBits[OVR_SUPPLY_EN] ? overrideBits[OVR_SUPPLY_VAL]
		: (strapSupply ? RAIL_1V8 : RAIL_3V3);
	assign effSample = overrideBits[OVR_TIMING_EN] ? overrideBits[OVR_SAMPLE_VAL]
		: (strapLog ? EDGE_RISE : EDGE_FALL);
	assign effDrive = overrideBits[OVR_TIMING_EN] ? overrideBits[OVR_DRIVE_VAL]
		: (strapTim ? EDGE_RISE : EDGE_FALL);
	// boot 0 with qualify 1 is undefined: neither mode is flagged
	assign decFlash = strapBoot;
	assign decDownload = !strapBoot && !strapQual;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			railSelect1v8 <= RAIL_3V3;
			bootFromFlash <= 1'b0;
			bootDownload <= 1'b0;
			uart0TransmitLogEn <= 1'b0;
			sdioSampleRising <= EDGE_FALL;
			sdioDriveRising <= EDGE_FALL;
			configValid <= 1'b0;
		end else begin
			railSelect1v8 <= effSupply;
			bootFromFlash <= decFlash;
			bootDownload <= decDownload;
			uart0TransmitLogEn <= strapLog;
			sdioSampleRising <= effSample;
			sdioDriveRising <= effDrive;
			configValid <= 1'b1;
		end
	end

	// ==========================================================
	// register port
	wire selStatus;
	wire selOverride;
	wire selEffective;
	wire [DATA_W-1:0] readMux;
	wire [EFF_W-1:0] effVec;

	assign selStatus = (regAddr == ADDR_STRAP_STATUS);
	assign selOverride = (regAddr == ADDR_OVERRIDE);
	assign selEffective = (regAddr == ADDR_EFFECTIVE);
	assign effVec = {configValid, sdioDriveRising, sdioSampleRising, uart0TransmitLogEn,
		bootDownload, bootFromFlash, railSelect1v8};
	// unmapped addresses read zero, writes there are dropped
	assign readMux = selStatus ? {{(DATA_W-STRAP_N){1'b0}}, strapLatch}
		: selOverride ? {{(DATA_W-OVR_W){1'b0}}, overrideBits}
		: selEffective ? {{(DATA_W-EFF_W){1'b0}}, effVec}
		: '0;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			overrideBits <= OVR_RESET;
		end else if (regWrite && selOverride) begin
			overrideBits <= regWdata[OVR_W-1:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			regRdata <= '0;
		end else if (regRead) begin
			regRdata <= readMux;
		end else begin
			regRdata <= '0;
		end
	end

endmodule // scb_strap_capture

/* sim/scb_strap_board.sv */
// partner: board pulls and host gpios on the five strap pins
`timescale 1ns/100ps
module scb_strap_board (
	// host gpio side
	input wire logic [4:0] drv,
	input wire logic [4:0] drvEn,
	// weak pulls from the device pads
	input wire logic [4:0] pullUp,
	input wire logic [4:0] pullDn,
	// resolved pin levels
	output logic [4:0] pins
);
	// ==========
	// pin resolution
	// supply pin has a strong board pull-up that beats the weak pull-down
	// a pin with no pull at all shows the inverse of the last drive, not a kept value
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			pins[i] = drvEn[i] ? drv[i] : pullUp[i] | (i == 0) | ~pullDn[i] & ~drv[i];
		end
	end
endmodule // scb_strap_board

/* sim/scb_strap_capture_properties.sv */
// checker: port properties of the strap capture block
`timescale 1ns/100ps
module scb_strap_capture_properties import scb_pkg::*; (
	// clock, reset and strap pins
	input wire logic clk_sys, rst_b, supplySelectStrap, bootSelectStrap, downloadQualifyStrap,
	input wire logic logAndTimingStrap, timingSelectStrap,
	// pulls and decoded outputs
	input wire logic [STRAP_N-1:0] strapPullUpEn, strapPullDownEn,
	input wire logic strapPinsReleased, configValid, railSelect1v8, bootFromFlash, bootDownload,
	input wire logic uart0TransmitLogEn, sdioSampleRising, sdioDriveRising,
	// register port
	input wire logic regRead,
	input wire logic [DATA_W-1:0] regRdata
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	a_pulls_off: assert property (strapPinsReleased |-> !(strapPullUpEn | strapPullDownEn))
		else $error("pulls on after release");
	a_released_held: assert property (strapPinsReleased |=> strapPinsReleased)
		else $error("pins taken back");
	a_capture_once: assert property ($rose(configValid) |-> $rose(strapPinsReleased))
		else $error("capture and release apart");
	a_rail_pick: assert property ($rose(configValid) |-> railSelect1v8 == $past(supplySelectStrap))
		else $error("rail decode wrong");
	a_boot_pick: assert property ($rose(configValid) |-> bootFromFlash == $past(bootSelectStrap)
		&& bootDownload == !($past(bootSelectStrap) || $past(downloadQualifyStrap)))
		else $error("boot decode wrong");
	a_log_edges: assert property ($rose(configValid) |-> uart0TransmitLogEn == $past(logAndTimingStrap)
		&& sdioSampleRising == $past(logAndTimingStrap) && sdioDriveRising == $past(timingSelectStrap))
		else $error("log or edge decode wrong");
	a_boot_stable: assert property (configValid |=> configValid
		&& $stable({bootFromFlash, bootDownload, uart0TransmitLogEn}))
		else $error("boot settings changed");
	a_read_idle: assert property (!$past(regRead) |-> regRdata == 0)
		else $error("read data outside its cycle");
endmodule // scb_strap_capture_properties
bind scb_strap_capture scb_strap_capture_properties scb_strap_capture_properties_inst (.*);

/* sim/scb_strap_capture_tb.sv */
// testbench: strap capture against a behavioural model
`timescale 1ns/100ps
module scb_strap_capture_tb import scb_pkg::*;;
	logic clk_sys, rst_b, regWrite, regRead, strapPinsReleased, configValid;
	logic railSelect1v8, bootFromFlash, bootDownload, uart0TransmitLogEn;
	logic sdioSampleRising, sdioDriveRising;
	logic [4:0] drv, drvEn, pins, s, strapPullUpEn, strapPullDownEn;
	logic [7:0] regAddr;
	logic [31:0] regWdata, regRdata, rnd;
	int err_total, checks_done, cyc;
	scb_strap_capture scb_strap_capture_inst (.*, .supplySelectStrap(pins[0]),
		.bootSelectStrap(pins[1]), .downloadQualifyStrap(pins[2]),
		.logAndTimingStrap(pins[3]), .timingSelectStrap(pins[4]));
	scb_strap_board scb_strap_board_inst (.drv(drv), .drvEn(drvEn), .pullUp(strapPullUpEn),
		.pullDn(strapPullDownEn), .pins(pins));
	// ==========
	// helpers
	function automatic logic [31:0] nxt(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic [31:0] eff(logic [4:0] p, logic [4:0] o);
		return {25'h0, 1'b1, o[2] ? o[4] : p[4], o[2] ? o[3] : p[3], p[3], ~p[1] & ~p[2], p[1],
			o[0] ? o[1] : p[0]};
	endfunction
	task automatic chk(logic [31:0] seen, logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(logic w, logic [7:0] a, logic [31:0] d, logic [31:0] e);
		@(posedge clk_sys);
		regWrite <= w;
		regRead <= ~w;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk_sys);
		regWrite <= 0;
		regRead <= 0;
		#1;
		if (!w) chk(regRdata, e);
	endtask
	task automatic wrap_up;
		$display("errors %0d checks %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// ==========
	// stimulus
	initial begin
		clk_sys = 0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 4000) begin
			err_total++;
			wrap_up();
		end
	end
	initial begin
		{rst_b, regWrite, regRead, regAddr, regWdata, drv, drvEn} = '0;
		rnd = 32'ha27dacb0;
		for (int i = 0; i < 40; i++) begin
			rnd = nxt(rnd);
			@(posedge clk_sys);
			rst_b <= 0;
			drv <= i < 32 ? i[4:0] : rnd[4:0];
			drvEn <= i < 32 ? 5'h1f : rnd[16:12];
			repeat (i ? 2 : 16) @(posedge clk_sys);
			chk(strapPullUpEn, PULL_UP_MASK);
			chk(strapPullDownEn, PULL_DOWN_MASK);
			// undriven pins fall to their pulls, supply to the board pull-up
			s = (drvEn & drv) | (~drvEn & 5'h1b);
			rst_b <= 1;
			@(posedge clk_sys);
			@(posedge clk_sys);
			drv <= ~drv;
			drvEn <= 5'h1f;
			bus(0, ADDR_EFFECTIVE, 0, eff(s, 0));
			bus(1, ADDR_STRAP_STATUS, rnd, 0);
			bus(1, ADDR_OVERRIDE, rnd >> 7, 0);
			bus(0, ADDR_OVERRIDE, 0, rnd[11:7]);
			bus(0, 8'h0c, 0, 0);
			bus(0, ADDR_STRAP_STATUS, 0, s);
			bus(0, ADDR_EFFECTIVE, 0, eff(s, rnd[11:7]));
			chk({26'h0, sdioDriveRising, sdioSampleRising, uart0TransmitLogEn, bootDownload,
				bootFromFlash, railSelect1v8}, eff(s, rnd[11:7]) & 32'h3f);
		end
		wrap_up();
	end
endmodule // scb_strap_capture_tb
